//--- fdc_status_defines.svh
`ifndef FDC_STATUS_DEFINES_SVH
`define FDC_STATUS_DEFINES_SVH

// first status byte field positions
`define ST0_CLASS_HI 7
`define ST0_CLASS_LO 6
`define ST0_POSDONE 5
`define ST0_EQFAULT 4
`define ST0_HEAD 2
`define ST0_UNIT_HI 1
`define ST0_UNIT_LO 0
// second status byte field positions
`define ST1_PASTEND 7
`define ST1_CRC 5
`define ST1_OVERRUN 4
`define ST1_MISSING 2
`define ST1_WPROT 1
`define ST1_SYNC 0
// limits and counts
`define LAST_SECTOR_LIMIT 8'hFF
`define RECAL_STEP_LIMIT 7'h50
`define INDEX_PULSE_LIMIT 2'h2
`define RECAL_SETTLE_LIMIT 2'h2
// reset values
`define STATUS_RESET 8'h00
// result byte selectors
`define RESULT_SEL_FIRST 1'b0
`define RESULT_SEL_SECOND 1'b1

`endif

//--- fdc_status_pkg.sv
package fdc_status_pkg;

  typedef enum logic [1:0] {
    class_normal = 2'h0,
    class_abnormal = 2'h1,
    class_invalid = 2'h2,
    class_polling = 2'h3
  } termination_class_t;

  typedef enum logic [2:0] {
    cmd_other,
    cmd_read_data,
    cmd_read_deleted,
    cmd_write_data,
    cmd_write_deleted,
    cmd_format_track,
    cmd_read_id,
    cmd_read_track
  } command_kind_t;

  typedef enum logic [1:0] {
    pos_none,
    pos_seek,
    pos_relative_seek,
    pos_recalibrate
  } position_kind_t;

  // one-cycle event strobes from the command sequencer and data path
  typedef struct packed {
    logic step_pulse;
    logic step_outward;
    logic position_done;
    logic sector_access;
    logic [7:0] sector_number;
    logic command_end;
    logic crc_id_error;
    logic crc_data_error;
    logic service_late;
    logic sector_not_found;
    logic id_unreadable;
    logic sequence_broken;
    logic id_mark_seen;
    logic data_mark_missing;
  } status_events_t;

  typedef struct packed {
    logic [7:0] first;
    logic [7:0] second;
  } status_bytes_t;

endpackage

//--- fdc_pin_sync.sv
`timescale 1ns/1ps
module fdc_pin_sync (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_out
);
  logic [2:0] stage1;
  logic [2:0] next_stage1;
  logic [2:0] next_pin_out;

  // stage1 feeds only the second flop
  always_comb begin
    next_stage1 = pin_in;
    next_pin_out = stage1;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stage1 <= 3'h0;
      pin_out <= 3'h0;
    end else begin
      stage1 <= next_stage1;
      pin_out <= next_pin_out;
    end
  end
endmodule

//--- fdc_index_counter.sv
`timescale 1ns/1ps
`include "fdc_status_defines.svh"
module fdc_index_counter (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic restart,
  input wire logic index_level,
  input wire logic mark_seen,
  output logic limit_hit
);
  logic index_prev;
  logic [1:0] pulses;
  logic next_index_prev;
  logic [1:0] next_pulses;
  logic next_limit_hit;

  always_comb begin
    next_index_prev = index_level;
    next_pulses = pulses;
    next_limit_hit = 1'b0;
    if (restart || mark_seen) begin
      next_pulses = 2'h0;
    end else if (index_level && !index_prev) begin
      if (pulses == `INDEX_PULSE_LIMIT - 2'h1) begin
        // second index pulse without an id mark
        next_limit_hit = 1'b1;
        next_pulses = 2'h0;
      end else begin
        next_pulses = pulses + 2'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      index_prev <= 1'b0;
      pulses <= 2'h0;
      limit_hit <= 1'b0;
    end else begin
      index_prev <= next_index_prev;
      pulses <= next_pulses;
      limit_hit <= next_limit_hit;
    end
  end
endmodule

//--- fdc_result_status.sv
`timescale 1ns/1ps
`include "fdc_status_defines.svh"

module fdc_result_status (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic command_start,
  input wire fdc_status_pkg::command_kind_t command_kind,
  input wire fdc_status_pkg::position_kind_t position_kind,
  input wire logic command_invalid,
  input wire logic polling_abort,
  input wire logic head_select,
  input wire logic [1:0] unit_select,
  input wire fdc_status_pkg::status_events_t events,
  input wire logic outer_track_sense,
  input wire logic write_protect_input,
  input wire logic rotation_index_input,
  input wire logic transfer_count_done,
  input wire logic result_phase,
  input wire logic result_sel,
  output logic [7:0] result_data,
  output logic result_valid,
  output fdc_status_pkg::status_bytes_t status
);
  import fdc_status_pkg::*;

  logic [2:0] pins_sync;
  logic track_zero;
  logic protect_level;
  logic index_level;
  logic index_limit;

  fdc_pin_sync pin_sync_u (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin_in({rotation_index_input, write_protect_input, outer_track_sense}),
    .pin_out(pins_sync)
  );

  always_comb begin
    track_zero = pins_sync[0];
    protect_level = pins_sync[1];
    index_level = pins_sync[2];
  end

  fdc_index_counter index_u (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .restart(command_start),
    .index_level(index_level),
    .mark_seen(events.id_mark_seen),
    .limit_hit(index_limit)
  );

  command_kind_t kind;
  position_kind_t pos_kind;
  logic [6:0] step_count;
  logic count_seen;
  termination_class_t term_class;
  logic positioning_complete;
  logic equipment_fault;
  logic past_last_sector;
  logic crc_fault;
  logic overrun;
  logic sector_missing;
  logic write_blocked;
  logic address_sync_lost;
  logic head_num;
  logic [1:0] unit_num;
  logic executing;
  logic [1:0] settle_count;

  command_kind_t next_kind;
  position_kind_t next_pos_kind;
  logic [6:0] next_step_count;
  logic next_count_seen;
  termination_class_t next_term_class;
  logic next_positioning_complete;
  logic next_equipment_fault;
  logic next_past_last_sector;
  logic next_crc_fault;
  logic next_overrun;
  logic next_sector_missing;
  logic next_write_blocked;
  logic next_address_sync_lost;
  logic next_head_num;
  logic [1:0] next_unit_num;
  logic next_executing;
  logic [1:0] next_settle_count;
  status_bytes_t next_status;
  logic [7:0] next_result_data;
  logic next_result_valid;
  logic any_error;

  function automatic logic is_read_write(input command_kind_t k);
    return (k == cmd_read_data) || (k == cmd_read_deleted) ||
           (k == cmd_write_data) || (k == cmd_write_deleted);
  endfunction

  function automatic logic is_writing(input command_kind_t k);
    return (k == cmd_write_data) || (k == cmd_write_deleted) ||
           (k == cmd_format_track);
  endfunction

  function automatic logic is_sector_read(input command_kind_t k);
    return (k == cmd_read_data) || (k == cmd_read_deleted);
  endfunction

  // format spans two index pulses on purpose, so it never hunts an id mark
  function automatic logic hunts_id_mark(input command_kind_t k);
    return is_read_write(k) || (k == cmd_read_id) || (k == cmd_read_track);
  endfunction

  // invalid outranks polling, polling outranks plain failure
  function automatic termination_class_t end_class(input logic invalid, input logic polling,
      input logic failed);
    termination_class_t c;
    if (invalid) begin
      c = class_invalid;
    end else if (polling) begin
      c = class_polling;
    end else if (failed) begin
      c = class_abnormal;
    end else begin
      c = class_normal;
    end
    return c;
  endfunction

  always_comb begin
    next_kind = kind;
    next_pos_kind = pos_kind;
    next_step_count = step_count;
    next_count_seen = count_seen;
    next_term_class = term_class;
    next_positioning_complete = positioning_complete;
    next_equipment_fault = equipment_fault;
    next_past_last_sector = past_last_sector;
    next_crc_fault = crc_fault;
    next_overrun = overrun;
    next_sector_missing = sector_missing;
    next_write_blocked = write_blocked;
    next_address_sync_lost = address_sync_lost;
    next_head_num = head_num;
    next_unit_num = unit_num;
    next_executing = executing;
    next_settle_count = settle_count;
    any_error = 1'b0;
    if (command_start) begin
      // clear on start
      // events of this cycle belong to the old command
      next_kind = command_kind;
      next_pos_kind = position_kind;
      next_step_count = 7'h0;
      next_count_seen = 1'b0;
      next_term_class = class_normal;
      next_positioning_complete = 1'b0;
      next_equipment_fault = 1'b0;
      next_past_last_sector = 1'b0;
      next_crc_fault = 1'b0;
      next_overrun = 1'b0;
      next_sector_missing = 1'b0;
      next_write_blocked = 1'b0;
      next_address_sync_lost = 1'b0;
      next_executing = 1'b1;
      next_settle_count = 2'h0;
      next_head_num = head_select;
      next_unit_num = unit_select;
    end else begin
      if (transfer_count_done) begin
        next_count_seen = 1'b1;
      end
      // saturate so a stuck drive cannot wrap the count
      if (events.step_pulse && step_count != `RECAL_STEP_LIMIT) begin
        next_step_count = step_count + 7'h1;
      end
      // recalibrate limit
      // wait out the pin sync, or a drive that just reached zero is flagged
      if (pos_kind == pos_recalibrate && step_count == `RECAL_STEP_LIMIT) begin
        if (settle_count != `RECAL_SETTLE_LIMIT) begin
          next_settle_count = settle_count + 2'h1;
        end else if (!track_zero) begin
          next_equipment_fault = 1'b1;
        end
      end
      if (pos_kind == pos_relative_seek && events.step_pulse && events.step_outward &&
          track_zero) begin
        next_equipment_fault = 1'b1;
      end
      if (events.position_done && pos_kind != pos_none) begin
        next_positioning_complete = 1'b1;
      end
      // beyond last sector
      // eight bits hold no later sector, so FF stands for it
      if (events.sector_access && events.sector_number == `LAST_SECTOR_LIMIT) begin
        next_past_last_sector = 1'b1;
      end
      if (events.command_end && is_read_write(kind) && !count_seen && !transfer_count_done) begin
        next_past_last_sector = 1'b1;
      end
      if (events.crc_id_error || events.crc_data_error) begin
        next_crc_fault = 1'b1;
      end
      if (events.service_late) begin
        next_overrun = 1'b1;
      end
      if (events.sector_not_found && is_sector_read(kind)) begin
        next_sector_missing = 1'b1;
      end
      if (events.id_unreadable && kind == cmd_read_id) begin
        next_sector_missing = 1'b1;
      end
      if (events.sequence_broken && kind == cmd_read_track) begin
        next_sector_missing = 1'b1;
      end
      if (executing && protect_level && is_writing(kind)) begin
        next_write_blocked = 1'b1;
      end
      if (executing && index_limit && hunts_id_mark(kind)) begin
        next_address_sync_lost = 1'b1;
      end
      if (events.data_mark_missing) begin
        next_address_sync_lost = 1'b1;
      end
      if (events.command_end) begin
        // judged on next values so a same-cycle fault counts
        any_error = next_equipment_fault || next_past_last_sector || next_crc_fault ||
                    next_overrun || next_sector_missing || next_write_blocked ||
                    next_address_sync_lost;
        next_term_class = end_class(command_invalid, polling_abort, any_error);
        // level pins would keep raising bits once the command is over
        next_executing = 1'b0;
      end
    end
    next_status.first = `STATUS_RESET;
    next_status.first[`ST0_CLASS_HI:`ST0_CLASS_LO] = next_term_class;
    next_status.first[`ST0_POSDONE] = next_positioning_complete;
    next_status.first[`ST0_EQFAULT] = next_equipment_fault;
    next_status.first[`ST0_HEAD] = next_head_num;
    next_status.first[`ST0_UNIT_HI:`ST0_UNIT_LO] = next_unit_num;
    next_status.second = `STATUS_RESET;
    next_status.second[`ST1_PASTEND] = next_past_last_sector;
    next_status.second[`ST1_CRC] = next_crc_fault;
    next_status.second[`ST1_OVERRUN] = next_overrun;
    next_status.second[`ST1_MISSING] = next_sector_missing;
    next_status.second[`ST1_WPROT] = next_write_blocked;
    next_status.second[`ST1_SYNC] = next_address_sync_lost;
    next_result_valid = result_phase;
    if (!result_phase) begin
      next_result_data = `STATUS_RESET;
    end else if (result_sel == `RESULT_SEL_FIRST) begin
      next_result_data = next_status.first;
    end else begin
      next_result_data = next_status.second;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      kind <= cmd_other;
      pos_kind <= pos_none;
      step_count <= 7'h0;
      count_seen <= 1'b0;
      term_class <= class_normal;
      positioning_complete <= 1'b0;
      equipment_fault <= 1'b0;
      past_last_sector <= 1'b0;
      crc_fault <= 1'b0;
      overrun <= 1'b0;
      sector_missing <= 1'b0;
      write_blocked <= 1'b0;
      address_sync_lost <= 1'b0;
      head_num <= 1'b0;
      unit_num <= 2'h0;
      executing <= 1'b0;
      settle_count <= 2'h0;
      status <= '0;
      result_data <= `STATUS_RESET;
      result_valid <= 1'b0;
    end else begin
      kind <= next_kind;
      pos_kind <= next_pos_kind;
      step_count <= next_step_count;
      count_seen <= next_count_seen;
      term_class <= next_term_class;
      positioning_complete <= next_positioning_complete;
      equipment_fault <= next_equipment_fault;
      past_last_sector <= next_past_last_sector;
      crc_fault <= next_crc_fault;
      overrun <= next_overrun;
      sector_missing <= next_sector_missing;
      write_blocked <= next_write_blocked;
      address_sync_lost <= next_address_sync_lost;
      head_num <= next_head_num;
      unit_num <= next_unit_num;
      executing <= next_executing;
      settle_count <= next_settle_count;
      status <= next_status;
      result_data <= next_result_data;
      result_valid <= next_result_valid;
    end
  end
endmodule

//--- fdc_result_status_properties.sv
`timescale 1ns/1ps
module fdc_result_status_properties
  import fdc_status_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic command_start,
  input wire fdc_status_pkg::command_kind_t command_kind,
  input wire fdc_status_pkg::position_kind_t position_kind,
  input wire logic command_invalid,
  input wire logic polling_abort,
  input wire logic head_select,
  input wire logic [1:0] unit_select,
  input wire fdc_status_pkg::status_events_t events,
  input wire logic result_phase,
  input wire logic result_sel,
  input wire logic [7:0] result_data,
  input wire logic result_valid,
  input wire fdc_status_pkg::status_bytes_t status
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  logic pos_active;

  // a seek end strobe counts only inside a positioning command
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pos_active <= 1'b0;
    end else if (command_start) begin
      pos_active <= position_kind != pos_none;
    end
  end

  a_unused_zero: assert property (
    !status.first[3] && !status.second[6] && !status.second[3]) else $error("unused bit set");
  a_start_clear: assert property (
    command_start |=> status.second == 8'h00 && status.first[7:4] == 4'h0)
    else $error("new command left old bits");
  a_head_unit: assert property (
    command_start |=> status.first[2] == $past(head_select)
      && status.first[1:0] == $past(unit_select)) else $error("head or unit wrong");
  a_crc_sets: assert property (
    (events.crc_id_error || events.crc_data_error) && !command_start |=> status.second[5])
    else $error("crc bit missing");
  a_late_sets: assert property (
    events.service_late && !command_start |=> status.second[4]) else $error("overrun missing");
  a_seek_done: assert property (
    events.position_done && pos_active && !command_start |=> status.first[5])
    else $error("seek end missing");
  a_past_end: assert property (
    events.sector_access && events.sector_number == 8'hFF && !command_start
      |=> status.second[7]) else $error("past end missing");
  a_invalid_class: assert property (
    events.command_end && command_invalid && !command_start |=> status.first[7:6] == 2'h2)
    else $error("invalid class wrong");
  a_poll_class: assert property (
    events.command_end && !command_invalid && polling_abort && !command_start
      |=> status.first[7:6] == 2'h3) else $error("polling class wrong");
  a_result_out: assert property (
    result_phase ##1 $stable(status) |-> result_valid
      && result_data == ($past(result_sel) ? status.second : status.first))
    else $error("result byte wrong");
  a_result_idle: assert property (
    !result_phase |=> result_data == 8'h00 && !result_valid) else $error("idle result not zero");
endmodule

bind fdc_result_status fdc_result_status_properties chk (.ref_clk, .sys_rst, .command_start,
  .command_kind, .position_kind, .command_invalid, .polling_abort, .head_select, .unit_select,
  .events, .result_phase, .result_sel, .result_data, .result_valid, .status);

//--- fdc_host_reader.sv
`timescale 1ns/1ps
module fdc_host_reader (
  input wire logic ref_clk,
  input wire logic [7:0] result_data,
  output logic result_phase,
  output logic result_sel
);
  initial begin
    result_phase = 1'b0;
    result_sel = 1'b0;
  end
  // reads both bytes
  // slow adds wait edges, as a busy host would
  task automatic read_both(input int slow, output logic [7:0] b0, output logic [7:0] b1);
    result_phase = 1'b1;
    result_sel = 1'b0;
    repeat (1 + slow) @(posedge ref_clk);
    #2;
    b0 = result_data;
    result_sel = 1'b1;
    @(posedge ref_clk);
    #2;
    b1 = result_data;
    result_phase = 1'b0;
  endtask
endmodule

//--- fdc_result_status_tb_top.sv
`timescale 1ns/1ps
module fdc_result_status_tb_top;
  import fdc_status_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic command_start = 1'b0;
  command_kind_t command_kind = cmd_other;
  position_kind_t position_kind = pos_none;
  logic command_invalid = 1'b0;
  logic polling_abort = 1'b0;
  logic head_select = 1'b0;
  logic [1:0] unit_select = 2'h0;
  status_events_t events = '0;
  status_events_t e = '0;
  logic outer_track_sense = 1'b0;
  logic write_protect_input = 1'b0;
  logic rotation_index_input = 1'b0;
  logic transfer_count_done = 1'b0;
  logic result_phase;
  logic result_sel;
  logic [7:0] result_data;
  logic result_valid;
  status_bytes_t status;
  logic [7:0] b0;
  logic [7:0] b1;
  int fails = 0;
  int checks_done = 0;

  always #10 ref_clk = ~ref_clk;

  fdc_result_status dut (.ref_clk, .sys_rst, .command_start, .command_kind, .position_kind,
    .command_invalid, .polling_abort, .head_select, .unit_select, .events, .outer_track_sense,
    .write_protect_input, .rotation_index_input, .transfer_count_done, .result_phase,
    .result_sel, .result_data, .result_valid, .status);
  fdc_host_reader host (.ref_clk, .result_data, .result_phase, .result_sel);

  task tick(input int n = 1);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task start(input command_kind_t k, input position_kind_t p, input logic h, input logic [1:0] u);
    command_kind = k;
    position_kind = p;
    head_select = h;
    unit_select = u;
    command_start = 1'b1;
    tick();
    command_start = 1'b0;
  endtask
  task fire;
    events = e;
    tick();
    events = '0;
    e = '0;
    tick();
  endtask
  task finish(input logic inv, input logic pol);
    command_invalid = inv;
    polling_abort = pol;
    e.command_end = 1'b1;
    fire();
    command_invalid = 1'b0;
    polling_abort = 1'b0;
  endtask
  // pins pass two sync flops, so each level is held three edges
  task idx_pulse;
    rotation_index_input = 1'b1;
    tick(3);
    rotation_index_input = 1'b0;
    tick(3);
  endtask
  task close_out;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task t_walk;
    start(cmd_read_data, pos_none, 1'b1, 2'h2);
    e.crc_data_error = 1'b1;
    fire();
    finish(1'b0, 1'b0);
    host.read_both(0, b0, b1);
    check("walk first", b0, 8'h46);
    check("walk second", b1, 8'hA0);
    check("valid", {7'h00, result_valid}, 8'h01);
    tick();
    check("idle data", result_data, 8'h00);
    check("idle valid", {7'h00, result_valid}, 8'h00);
    // write with count seen: clean end, old bits gone
    start(cmd_write_data, pos_none, 1'b0, 2'h3);
    transfer_count_done = 1'b1;
    tick();
    transfer_count_done = 1'b0;
    finish(1'b0, 1'b0);
    host.read_both(3, b0, b1);
    check("clean first", b0, 8'h03);
    check("clean second", b1, 8'h00);
    $display("test walk done");
  endtask
  task t_class;
    for (int i = 0; i < 2; i++) begin
      start(cmd_other, pos_none, 1'b0, 2'h0);
      finish(i == 0, 1'b1);
      check("class", status.first, (i == 0) ? 8'h80 : 8'hC0);
    end
    $display("test class done");
  endtask
  task t_position;
    start(cmd_other, pos_relative_seek, 1'b0, 2'h0);
    outer_track_sense = 1'b1;
    tick(3);
    e.step_pulse = 1'b1;
    e.step_outward = 1'b1;
    fire();
    e.position_done = 1'b1;
    fire();
    check("rel seek", status.first & 8'h30, 8'h30);
    outer_track_sense = 1'b0;
    start(cmd_other, pos_recalibrate, 1'b0, 2'h0);
    tick(3);
    repeat (79) begin
      e.step_pulse = 1'b1;
      fire();
    end
    tick(3);
    check("recal 79", status.first & 8'h10, 8'h00);
    e.step_pulse = 1'b1;
    fire();
    tick(3);
    check("recal 80", status.first & 8'h10, 8'h10);
    start(cmd_other, pos_none, 1'b0, 2'h0);
    e.position_done = 1'b1;
    fire();
    check("no seek", status.first & 8'h20, 8'h00);
    start(cmd_other, pos_seek, 1'b0, 2'h0);
    e.position_done = 1'b1;
    fire();
    check("seek", status.first & 8'h20, 8'h20);
    $display("test position done");
  endtask
  task t_missing;
    for (int s = 0; s < 3; s++) begin
      for (int k = 0; k < 8; k++) begin
        start(command_kind_t'(k[2:0]), pos_none, 1'b0, 2'h0);
        if (s == 0) e.sector_not_found = 1'b1;
        else if (s == 1) e.id_unreadable = 1'b1;
        else e.sequence_broken = 1'b1;
        fire();
        check("missing", status.second & 8'h04, ((s == 0 && (k == 1 || k == 2))
          || (s == 1 && k == 6) || (s == 2 && k == 7)) ? 8'h04 : 8'h00);
      end
    end
    $display("test missing done");
  endtask
  task t_protect;
    for (int k = 1; k < 6; k++) begin
      start(command_kind_t'(k[2:0]), pos_none, 1'b0, 2'h0);
      write_protect_input = 1'b1;
      tick(4);
      write_protect_input = 1'b0;
      tick(3);
      check("protect", status.second & 8'h02, (k >= 3) ? 8'h02 : 8'h00);
    end
    $display("test protect done");
  endtask
  task t_marks;
    start(cmd_read_data, pos_none, 1'b0, 2'h0);
    idx_pulse();
    e.id_mark_seen = 1'b1;
    fire();
    idx_pulse();
    check("mark seen", status.second & 8'h01, 8'h00);
    idx_pulse();
    check("two index", status.second & 8'h01, 8'h01);
    start(cmd_read_data, pos_none, 1'b0, 2'h0);
    e.data_mark_missing = 1'b1;
    fire();
    check("data mark", status.second & 8'h01, 8'h01);
    start(cmd_format_track, pos_none, 1'b0, 2'h0);
    idx_pulse();
    idx_pulse();
    check("format index", status.second & 8'h01, 8'h00);
    start(cmd_read_id, pos_none, 1'b0, 2'h0);
    finish(1'b0, 1'b0);
    idx_pulse();
    idx_pulse();
    check("after end", status.second & 8'h01, 8'h00);
    $display("test marks done");
  endtask
  task t_sector;
    start(cmd_read_data, pos_none, 1'b0, 2'h0);
    e.sector_access = 1'b1;
    e.sector_number = 8'hFE;
    fire();
    check("sector FE", status.second & 8'h80, 8'h00);
    e.sector_access = 1'b1;
    e.sector_number = 8'hFF;
    fire();
    check("sector FF", status.second & 8'h80, 8'h80);
    e.service_late = 1'b1;
    fire();
    check("late", status.second & 8'h10, 8'h10);
    $display("test sector done");
  endtask

  initial begin
    tick(12);
    sys_rst = 1'b0;
    check("reset first", status.first, 8'h00);
    check("reset second", status.second, 8'h00);
    t_walk();
    t_class();
    t_position();
    t_missing();
    t_protect();
    t_marks();
    t_sector();
    close_out();
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    fails++;
    close_out();
  end
endmodule
